/* File: rtl/sio_pkg.sv */
// Shared types and constants for the serial I/O channel
`default_nettype none
package sio_pkg;
  // ----------------------------------------------------------------
  // Modes and configuration
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SIO_ASYNC, SIO_SYNC, SIO_I2C} sio_mode_t;

  localparam int        SIO_DATA_W       = 8;     // Data word width
  localparam int        SIO_BRG_W        = 8;     // Baud rate generator reload width

  // Clock source select codes
  localparam logic [1:0] SIO_CLK_DIV1    = 2'h0;  // sio_clock_div1
  localparam logic [1:0] SIO_CLK_DIV2    = 2'h1;  // sio_clock_div2
  localparam logic [1:0] SIO_CLK_DIV8    = 2'h2;  // sio_clock_div8
  localparam logic [1:0] SIO_CLK_DIV32   = 2'h3;  // sio_clock_div32

  // Prescaler masks: enable fires when all masked bits are ones
  localparam logic [4:0] SIO_MASK_DIV1   = 5'h00;
  localparam logic [4:0] SIO_MASK_DIV2   = 5'h01;
  localparam logic [4:0] SIO_MASK_DIV8   = 5'h07;
  localparam logic [4:0] SIO_MASK_DIV32  = 5'h1f;

  // ----------------------------------------------------------------
  // Bit timing: each bit is four overflows of the baud rate generator
  // ----------------------------------------------------------------
  localparam logic [1:0] SIO_Q_SCL_LOW   = 2'h0;  // Clock falls, data normally changes
  localparam logic [1:0] SIO_Q_SAMPLE    = 2'h2;  // Clock rises, receiver samples
  localparam logic [1:0] SIO_Q_LAST      = 2'h3;  // Last quarter of a bit
  localparam logic [1:0] SIO_TX_START_OVF = 2'h2; // Overflow on which shifting starts

  // Frame lengths in bits
  localparam logic [3:0] SIO_FRAME_ASYNC = 4'ha;  // Start, 8 data, stop
  localparam logic [3:0] SIO_FRAME_SYNC  = 4'h8;  // 8 data
  localparam logic [3:0] SIO_FRAME_I2C   = 4'h9;  // 8 data, acknowledge slot

  // Receive bit indices
  localparam logic [3:0] SIO_OVR_SYNC_BIT  = 4'h6; // 7th bit of a synchronous word
  localparam logic [3:0] SIO_OVR_ASYNC_BIT = 4'h8; // Bit just ahead of the stop bit
  localparam logic [3:0] SIO_RX_SYNC_LAST  = 4'h7; // Last synchronous bit
  localparam logic [3:0] SIO_RX_STOP_BIT   = 4'h9; // Asynchronous stop bit

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    sio_mode_t             mode;     // Channel mode
    logic [1:0]            clk_sel;  // Clock source select
    logic [SIO_BRG_W-1:0]  brg_div;  // Baud rate generator reload
    logic                  sda_dly;  // SDA delay in generator overflows
  } sio_cfg_t;

  typedef struct packed {
    logic                  full;     // Receive buffer holds a word
    logic [SIO_DATA_W-1:0] data;     // Receive buffer contents
  } sio_rx_t;
endpackage
`default_nettype wire

/* File: rtl/sio_buf2.sv */
// Two-entry buffer with valid/ready on both sides
`default_nettype none
module sio_buf2 #(
  parameter int W = 8                         // Word width
) (
  input  wire logic         clock,            // System clock
  input  wire logic         rstn,             // Asynchronous reset, active low
  input  wire logic         in_valid,         // Source offers a word
  output logic              in_ready,         // Buffer has room
  input  wire logic [W-1:0] in_data,          // Word from source
  output logic              out_valid,        // Buffer holds a word
  input  wire logic         out_ready,        // Sink takes the word
  output logic [W-1:0]      out_data          // Oldest word
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [W-1:0] mem_r [2];                    // Two entries
  logic [W-1:0] mem_nxt [2];
  logic         wp_r, wp_nxt;                 // Write pointer
  logic         rp_r, rp_nxt;                 // Read pointer
  logic [1:0]   cnt_r, cnt_nxt;               // Occupancy
  logic         push, pop;

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and occupancy update
  always_comb begin
    mem_nxt = mem_r;
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = in_data;
      wp_nxt        = ~wp_r;
    end
    if (pop) begin
      rp_nxt = ~rp_r;
    end
    // Both at once leaves the count unchanged
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  // Registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      wp_r     <= 1'b0;
      rp_r     <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      mem_r    <= mem_nxt;
      wp_r     <= wp_nxt;
      rp_r     <= rp_nxt;
      cnt_r    <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/sio_channel.sv */
// Serial I/O channel: asynchronous, clock-synchronous and I2C modes
`default_nettype none
module sio_channel
  import sio_pkg::*;
(
  input  wire logic                      clock,     // System clock, 125 MHz
  input  wire logic                      rstn,      // Asynchronous reset, active low
  input  wire sio_pkg::sio_cfg_t         cfg,       // Mode, clock select, reload, SDA delay
  input  wire logic                      tx_valid,  // Software writes transmit data
  output logic                           tx_ready,  // Transmit buffer has room
  input  wire logic [sio_pkg::SIO_DATA_W-1:0] tx_data, // Transmit word
  input  wire logic                      i2c_start, // Request a start condition
  input  wire logic                      i2c_stop,  // Request a stop condition
  output logic                           busy,      // Transmitter not idle
  input  wire logic                      rx_read,   // Software reads the receive buffer
  output sio_pkg::sio_rx_t               rx_out,    // Receive buffer and full flag
  input  wire logic                      ovr_clr,   // Clear overrun flag
  output logic                           ovr_err,   // Sticky overrun flag
  output logic                           rts_n,     // Ready to receive, active low
  output logic                           txd,       // Serial data out
  input  wire logic                      rxd,       // Serial data in
  output logic                           sclk_o,    // Synchronous transfer clock out
  output logic                           scl_o,     // SCL drive value
  output logic                           scl_oe_n,  // SCL drive enable, low drives
  input  wire logic                      scl_i,     // SCL wire level
  output logic                           sda_o,     // SDA drive value
  output logic                           sda_oe_n,  // SDA drive enable, low drives
  input  wire logic                      sda_i      // SDA wire level
);
  import sio_pkg::*;

  // ----------------------------------------------------------------
  // Prescaler and baud rate generator
  // ----------------------------------------------------------------
  logic [4:0]           pre_r, pre_nxt;      // Free running prescaler
  logic [SIO_BRG_W-1:0] brg_r, brg_nxt;      // baud_rate_generator down counter
  logic [4:0]           pre_mask;
  logic                 sio_en;              // Selected source clock enable
  logic                 ovf;                 // Generator overflow pulse
  logic                 i2c;

  assign i2c = (cfg.mode == SIO_I2C);

  // Source select
  always_comb begin
    unique case (cfg.clk_sel)
      SIO_CLK_DIV1:  pre_mask = SIO_MASK_DIV1;
      SIO_CLK_DIV2:  pre_mask = SIO_MASK_DIV2;
      SIO_CLK_DIV8:  pre_mask = SIO_MASK_DIV8;
      SIO_CLK_DIV32: pre_mask = SIO_MASK_DIV32;
    endcase
    sio_en  = ((pre_r & pre_mask) == pre_mask);
    ovf     = sio_en && (brg_r == '0);
    pre_nxt = pre_r + 5'h01;
    brg_nxt = brg_r;
    if (sio_en) begin
      brg_nxt = ovf ? cfg.brg_div : brg_r - {{(SIO_BRG_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pre_r <= 5'h00;
      brg_r <= '0;
    end else begin
      pre_r <= pre_nxt;
      brg_r <= brg_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Transmit buffer: a stalled shifter fills it and back-pressures software
  // ----------------------------------------------------------------
  logic                  b_valid, b_ready;
  logic [SIO_DATA_W-1:0] b_data;
  logic [SIO_DATA_W-1:0] b_rev;              // Buffered word, bit order reversed

  // I2C bytes leave MSB first; plain wiring avoids a streaming operator inside a concatenation
  for (genvar gi = 0; gi < SIO_DATA_W; gi++) begin : g_rev
    assign b_rev[gi] = b_data[SIO_DATA_W-1-gi];
  end

  sio_buf2 #(.W(SIO_DATA_W)) u_txbuf (
    .clock     (clock),
    .rstn      (rstn),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (b_valid),
    .out_ready (b_ready),
    .out_data  (b_data)
  );

  // ----------------------------------------------------------------
  // Transmitter and I2C condition generator
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_SHIFT, TX_START, TX_STOP} sio_tx_state_t;
  sio_tx_state_t ts_r, ts_nxt;
  logic [1:0]    wcnt_r, wcnt_nxt;           // Overflows seen since the write
  logic [1:0]    q_r, q_nxt;                 // Quarter within a bit
  logic [9:0]    sh_r, sh_nxt;               // Outgoing bits, LSB first
  logic [3:0]    nb_r, nb_nxt;               // Bits left in the frame
  logic          line_r, line_nxt;           // Data line level
  logic          sclk_r, sclk_nxt;           // Clock line level
  logic          adv;                        // Overflow not held by clock stretching
  logic          bit_q;                      // A quarter step of a data bit
  logic [1:0]    qeff;                       // Quarter acted on this step
  logic [1:0]    data_q;                     // Quarter on which data changes
  logic          sync_smp;                   // Synchronous receive sample strobe

  // A slave holding SCL low freezes the bit timing
  assign adv    = ovf && !(i2c && sclk_r && !scl_i);
  assign bit_q  = adv && ((ts_r == TX_SHIFT) || (ts_r == TX_WAIT && wcnt_r == SIO_TX_START_OVF - 2'h1));
  assign qeff   = (ts_r == TX_WAIT) ? SIO_Q_SCL_LOW : q_r;
  assign data_q = i2c ? {1'b0, cfg.sda_dly} : SIO_Q_SCL_LOW;
  assign sync_smp = bit_q && (cfg.mode == SIO_SYNC) && (qeff == SIO_Q_SAMPLE);
  assign b_ready  = (ts_r == TX_IDLE) && !(i2c && (i2c_start || i2c_stop));
  assign busy     = (ts_r != TX_IDLE);

  always_comb begin
    ts_nxt   = ts_r;
    wcnt_nxt = wcnt_r;
    q_nxt    = q_r;
    sh_nxt   = sh_r;
    nb_nxt   = nb_r;
    line_nxt = line_r;
    sclk_nxt = sclk_r;
    unique case (ts_r)
      TX_IDLE: begin
        q_nxt    = 2'h0;
        wcnt_nxt = 2'h0;
        // Conditions take priority over data in I2C mode
        if (i2c && i2c_start) begin
          ts_nxt = TX_START;
        end else if (i2c && i2c_stop) begin
          ts_nxt = TX_STOP;
        end else if (b_valid) begin
          ts_nxt = TX_WAIT;
          unique case (cfg.mode)
            SIO_ASYNC: begin
              sh_nxt = {1'b1, b_data, 1'b0};
              nb_nxt = SIO_FRAME_ASYNC;
            end
            SIO_SYNC: begin
              sh_nxt = {2'b11, b_data};
              nb_nxt = SIO_FRAME_SYNC;
            end
            default: begin
              // I2C sends MSB first, then releases SDA for acknowledge
              sh_nxt = {2'b11, b_rev};
              nb_nxt = SIO_FRAME_I2C;
            end
          endcase
        end
      end
      TX_WAIT: begin
        // The first overflow is only counted; the second starts the frame
        if (adv) begin
          wcnt_nxt = wcnt_r + 2'h1;
        end
        if (bit_q) begin
          ts_nxt = TX_SHIFT;
          q_nxt  = 2'h1;
        end
      end
      TX_SHIFT: begin
        if (adv) begin
          q_nxt = q_r + 2'h1;
          if (q_r == SIO_Q_LAST) begin
            sh_nxt = {1'b1, sh_r[9:1]};
            nb_nxt = nb_r - 4'h1;
            if (nb_r == 4'h1) begin
              ts_nxt = TX_IDLE;
            end
          end
        end
      end
      TX_START: begin
        if (adv) begin
          q_nxt = q_r + 2'h1;
          unique case (q_r)
            2'h0: begin
              line_nxt = 1'b1;
              sclk_nxt = 1'b1;
            end
            2'h1: line_nxt = 1'b0;
            2'h2: sclk_nxt = 1'b0;
            2'h3: ts_nxt   = TX_IDLE;
          endcase
        end
      end
      TX_STOP: begin
        if (adv) begin
          q_nxt = q_r + 2'h1;
          unique case (q_r)
            2'h0: begin
              line_nxt = 1'b0;
              sclk_nxt = 1'b0;
            end
            2'h1: sclk_nxt = 1'b1;
            2'h2: line_nxt = 1'b1;
            2'h3: ts_nxt   = TX_IDLE;
          endcase
        end
      end
      default: ts_nxt = TX_IDLE;
    endcase
    // Data bit shaping, shared by the first bit and the rest
    if (bit_q) begin
      if (qeff == data_q) begin
        line_nxt = sh_r[0];
      end
      if (qeff == SIO_Q_SCL_LOW) begin
        sclk_nxt = 1'b0;
      end else if (qeff == SIO_Q_SAMPLE) begin
        sclk_nxt = 1'b1;
      end
    end
    // Idle async line rests high; I2C keeps the level the acknowledge slot left
    if (ts_r == TX_SHIFT && ts_nxt == TX_IDLE && !i2c) begin
      line_nxt = 1'b1;
      sclk_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ts_r   <= TX_IDLE;
      wcnt_r <= 2'h0;
      q_r    <= 2'h0;
      sh_r   <= 10'h3ff;
      nb_r   <= 4'h0;
      line_r <= 1'b1;
      sclk_r <= 1'b1;
    end else begin
      ts_r   <= ts_nxt;
      wcnt_r <= wcnt_nxt;
      q_r    <= q_nxt;
      sh_r   <= sh_nxt;
      nb_r   <= nb_nxt;
      line_r <= line_nxt;
      sclk_r <= sclk_nxt;
    end
  end

  // Open-drain pins only ever pull low
  assign txd      = line_r;
  assign sclk_o   = sclk_r;
  assign sda_o    = 1'b0;
  assign scl_o    = 1'b0;
  assign sda_oe_n = !(i2c && !line_r);
  assign scl_oe_n = !(i2c && !sclk_r);

  // ----------------------------------------------------------------
  // Receiver, receive buffer, overrun and ready-to-receive
  // ----------------------------------------------------------------
  typedef enum logic {RX_IDLE, RX_BUSY} sio_rx_state_t;
  sio_rx_state_t         rs_r, rs_nxt;
  logic [1:0]            rq_r, rq_nxt;       // Async quarter counter
  logic [3:0]            rb_r, rb_nxt;       // Bit index in the frame
  logic [SIO_DATA_W-1:0] rsh_r, rsh_nxt;     // Incoming bits
  logic                  stf_r, stf_nxt;     // Frame began with buffer full
  logic [SIO_DATA_W-1:0] rbuf_r, rbuf_nxt;   // rx_buffer_reg
  logic                  full_r, full_nxt;
  logic                  ovr_r, ovr_nxt;
  logic                  rts_n_r, rts_n_nxt;
  logic                  done, ovr_set, rd;

  assign rd = rx_read && full_r;

  always_comb begin
    rs_nxt  = rs_r;
    rq_nxt  = rq_r;
    rb_nxt  = rb_r;
    rsh_nxt = rsh_r;
    stf_nxt = stf_r;
    done    = 1'b0;
    ovr_set = 1'b0;
    if (cfg.mode == SIO_ASYNC) begin
      if (rs_r == RX_IDLE) begin
        if (ovf && !rxd) begin
          rs_nxt  = RX_BUSY;
          rq_nxt  = 2'h1;
          rb_nxt  = 4'h0;
          stf_nxt = full_r;
        end
      end else if (ovf) begin
        rq_nxt = rq_r + 2'h1;
        if (rq_r == SIO_Q_LAST) begin
          rb_nxt = rb_r + 4'h1;
        end
        if (rq_r == SIO_Q_SAMPLE) begin
          if (rb_r == 4'h0 && rxd) begin
            rs_nxt = RX_IDLE;          // Glitch, not a start bit
          end else if (rb_r == SIO_RX_STOP_BIT) begin
            rs_nxt = RX_IDLE;
            done   = 1'b1;
          end else if (rb_r != 4'h0) begin
            rsh_nxt = {rxd, rsh_r[SIO_DATA_W-1:1]};
          end
          if (rb_r == SIO_OVR_ASYNC_BIT && stf_r && full_r) begin
            ovr_set = 1'b1;
          end
        end
      end
    end else if (cfg.mode == SIO_SYNC) begin
      if (sync_smp) begin
        rsh_nxt = {rxd, rsh_r[SIO_DATA_W-1:1]};
        rb_nxt  = rb_r + 4'h1;
        if (rs_r == RX_IDLE) begin
          rs_nxt  = RX_BUSY;
          rb_nxt  = 4'h1;
          stf_nxt = full_r;
        end else begin
          if (rb_r == SIO_OVR_SYNC_BIT && stf_r && full_r) begin
            ovr_set = 1'b1;
          end
          if (rb_r == SIO_RX_SYNC_LAST) begin
            rs_nxt = RX_IDLE;
            done   = 1'b1;
          end
        end
      end
    end else begin
      rs_nxt = RX_IDLE;
    end
    // A finished word is kept only if the buffer was emptied in time
    rbuf_nxt = (done && !full_r) ? rsh_nxt : rbuf_r;
    full_nxt = rd ? 1'b0 : (full_r || done);
    // Not ready once a word is held; ready again only on a read
    rts_n_nxt = rd ? 1'b0 : (rts_n_r || (done && !full_r));
    // Set beats clear
    ovr_nxt = ovr_set || (ovr_r && !ovr_clr);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rs_r    <= RX_IDLE;
      rq_r    <= 2'h0;
      rb_r    <= 4'h0;
      rsh_r   <= '0;
      stf_r   <= 1'b0;
      rbuf_r  <= '0;
      full_r  <= 1'b0;
      ovr_r   <= 1'b0;
      rts_n_r <= 1'b0;
    end else begin
      rs_r    <= rs_nxt;
      rq_r    <= rq_nxt;
      rb_r    <= rb_nxt;
      rsh_r   <= rsh_nxt;
      stf_r   <= stf_nxt;
      rbuf_r  <= rbuf_nxt;
      full_r  <= full_nxt;
      ovr_r   <= ovr_nxt;
      rts_n_r <= rts_n_nxt;
    end
  end

  assign rx_out  = '{full: full_r, data: rbuf_r};
  assign ovr_err = ovr_r;
  assign rts_n   = rts_n_r;
endmodule
`default_nettype wire

/* File: verif/sio_chk.sv */
// Port checker of the serial channel
`default_nettype none
module sio_chk
  import sio_pkg::*;
(
  input wire logic              clock,     // System clock
  input wire logic              rstn,      // Reset, active low
  input wire sio_pkg::sio_cfg_t cfg,       // Channel setup
  input wire logic              tx_valid,  // Write request
  input wire logic              tx_ready,  // Buffer room
  input wire logic              i2c_start, // Start request
  input wire logic              busy,      // Transmitter active
  input wire logic              rx_read,   // Buffer read
  input wire sio_pkg::sio_rx_t  rx_out,    // Receive buffer
  input wire logic              ovr_clr,   // Overrun clear
  input wire logic              ovr_err,   // Overrun flag
  input wire logic              rts_n,     // Ready to receive
  input wire logic              txd,       // Serial out
  input wire logic              scl_oe_n,  // SCL enable
  input wire logic              scl_i,     // SCL wire
  input wire logic              sda_oe_n   // SDA enable
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------
  // One clock domain, so clock and reset are shared
  // ------------------------------------------------
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);

  rts_full_a:
    assert property (rts_n == rx_out.full) else $error("rts_n and buffer full disagree");
  read_empty_a:
    assert property (rx_read && rx_out.full |=> !rx_out.full && !rts_n) else $error("read left buffer full");
  ovr_cause_a:
    assert property ($rose(ovr_err) |-> $past(rx_out.full)) else $error("overrun with empty buffer");
  ovr_hold_a:
    assert property (ovr_err && !ovr_clr |=> ovr_err) else $error("overrun flag dropped");
  data_hold_a:
    assert property (rx_out.full && !rx_read |=> $stable(rx_out.data)) else $error("unread word overwritten");
  tx_wait_a:
    assert property ($rose(busy) && cfg.mode == SIO_ASYNC |-> txd [*2]) else $error("start bit too early");
  tx_take_a:
    assert property (tx_valid && tx_ready && !busy |-> ##[1:2] busy) else $error("write not started");
  txd_idle_a:
    assert property (cfg.mode == SIO_ASYNC && !busy |-> txd) else $error("txd low while idle");
  i2c_req_a:
    assert property (cfg.mode == SIO_I2C && i2c_start && !busy |-> ##[1:2] busy) else $error("start ignored");
  i2c_start_a:
    assert property (cfg.mode == SIO_I2C && $fell(sda_oe_n) && scl_oe_n && scl_i |-> ##[1:300] !scl_oe_n)
      else $error("start not followed by clock low");
endmodule
bind sio_channel sio_chk sio_chk_i (
  .clock(clock), .rstn(rstn), .cfg(cfg), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .i2c_start(i2c_start), .busy(busy), .rx_read(rx_read), .rx_out(rx_out), .ovr_clr(ovr_clr),
  .ovr_err(ovr_err), .rts_n(rts_n), .txd(txd), .scl_oe_n(scl_oe_n), .scl_i(scl_i), .sda_oe_n(sda_oe_n));
`default_nettype wire

/* File: verif/sio_peer.sv */
// Far-end serial peer that sends asynchronous frames
`default_nettype none
module sio_peer #(
  parameter int BIT_CLK = 4             // Clocks per bit
) (
  input  wire logic       clock,        // System clock
  output var  logic       rxd,          // Line into the channel
  output var  logic [3:0] bit_no        // Bit being driven, f when idle
);
  timeunit 1ns;
  timeprecision 1ps;
  // Line rests at mark level between frames
  initial begin
    rxd = 1'b1;
    bit_no = 4'hf;
  end
  // Start, data LSB first, stop; call at a falling edge
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd = f[i];
      bit_no = 4'(i);
      repeat (BIT_CLK) @(negedge clock);
    end
    bit_no = 4'hf;
  endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking testbench of the serial channel
`default_nettype none
module tb_top import sio_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rstn, tx_valid, tx_ready, i2c_start, i2c_stop, busy, rx_read;
  logic ovr_clr, ovr_err, rts_n, txd, rxd, sclk_o, scl_o, scl_oe_n, sda_o, sda_oe_n;
  logic [7:0] tx_data;
  logic [3:0] bit_no;
  logic       scl_w, sda_w;
  sio_cfg_t   cfg;
  sio_rx_t    rx_out;
  int         n_mismatch, total_checks;
  // Open-drain wires with pull-ups
  assign scl_w = scl_oe_n ? 1'b1 : scl_o;
  assign sda_w = sda_oe_n ? 1'b1 : sda_o;

  sio_channel sio_channel_i (.clock(clock), .rstn(rstn), .cfg(cfg), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .i2c_start(i2c_start), .i2c_stop(i2c_stop),
    .busy(busy), .rx_read(rx_read), .rx_out(rx_out), .ovr_clr(ovr_clr), .ovr_err(ovr_err),
    .rts_n(rts_n), .txd(txd), .rxd(rxd), .sclk_o(sclk_o), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .scl_i(scl_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .sda_i(sda_w));
  sio_peer #(.BIT_CLK(4)) sio_peer_i (.clock(clock), .rxd(rxd), .bit_no(bit_no));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic setc(input sio_mode_t m, input logic [1:0] s, input logic [7:0] b, input logic d);
    @(negedge clock);
    cfg = '{mode: m, clk_sel: s, brg_div: b, sda_dly: d};
  endtask
  // Hold the write until the buffer has room; an idle edge first keeps back-to-back calls apart
  task automatic wr(input logic [7:0] d);
    @(negedge clock);
    tx_valid = 1'b1;
    tx_data = d;
    while (!tx_ready) @(negedge clock);
    @(negedge clock);
    tx_valid = 1'b0;
  endtask
  task automatic rd();
    rx_read = 1'b1;
    @(negedge clock);
    rx_read = 1'b0;
  endtask
  task automatic pulse_clr();
    ovr_clr = 1'b1;
    @(negedge clock);
    ovr_clr = 1'b0;
  endtask
  // Sample an async frame mid-bit, p clocks per overflow
  task automatic txchk(input logic [7:0] d, input int p);
    while (txd !== 1'b0) @(negedge clock);
    cyc(2 * p);
    chk(txd, 0);
    for (int i = 0; i < 8; i++) begin
      cyc(4 * p);
      chk(txd, d[i]);
    end
    cyc(4 * p);
    chk(txd, 1);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_rx();
    setc(SIO_ASYNC, SIO_CLK_DIV1, 8'h00, 1'b0);
    sio_peer_i.send(8'ha5);
    cyc(4);
    chk(rx_out, {1'b1, 8'ha5});
    chk(rts_n, 1);
    rd();
    chk({rx_out.full, rts_n}, 0);
  endtask
  // Second frame lands on a full buffer
  task automatic t_ovr();
    sio_peer_i.send(8'h3c);
    fork
      sio_peer_i.send(8'hc3);
      begin
        wait (bit_no == 4'h8);
        chk(ovr_err, 0);
        wait (bit_no == 4'h9);
        chk(ovr_err, 1);
      end
    join
    cyc(4);
    chk(rx_out.data, 8'h3c);
    pulse_clr();
    chk(ovr_err, 0);
    rd();
    sio_peer_i.send(8'h81);
    cyc(4);
    chk({ovr_err, rx_out}, {1'b0, 1'b1, 8'h81});
    rd();
  endtask
  // Three writes fill the shifter and both buffer entries, which then refuse more; all leave in order
  task automatic t_fill();
    wr(8'ha1);
    wr(8'hb2);
    wr(8'hc3);
    chk(tx_ready, 0);
    txchk(8'ha1, 1);
    txchk(8'hb2, 1);
    txchk(8'hc3, 1);
    while (busy) @(negedge clock);
  endtask
  task automatic t_tx(input logic [1:0] s, input logic [7:0] b, input logic [7:0] d);
    int p;
    int lat;
    p = (b + 1) * (s == 2'h0 ? 1 : s == 2'h1 ? 2 : s == 2'h2 ? 8 : 32);
    setc(SIO_ASYNC, s, b, 1'b0);
    wr(d);
    while (!busy) @(negedge clock);
    lat = 0;
    while (txd !== 1'b0) begin
      @(negedge clock);
      lat++;
    end
    chk(lat > p && lat <= 2 * p + 2, 1);
    txchk(d, p);
    while (busy) @(negedge clock);
  endtask
  // Overrun in clocked mode must wait for the 7th clock rise
  task automatic t_sync();
    int   r;
    logic ps;
    setc(SIO_SYNC, SIO_CLK_DIV1, 8'h00, 1'b0);
    wr(8'h00);
    while (!busy) @(negedge clock);
    while (busy) @(negedge clock);
    cyc(2);
    chk(rx_out, {1'b1, 8'hff});
    wr(8'h00);
    r = 0;
    ps = sclk_o;
    while (r < 8) begin
      @(negedge clock);
      if (!ps && sclk_o) begin
        r++;
        if (r == 6) chk(ovr_err, 0);
        if (r == 7) chk(ovr_err, 1);
      end
      ps = sclk_o;
    end
    chk(ovr_err, 1);
    while (busy) @(negedge clock);
    pulse_clr();
    rd();
  endtask
  // Start, one byte, stop; SDA lag after SCL falls is d overflows of 8 clocks
  task automatic t_i2c(input logic d);
    int   cnt;
    logic ps;
    setc(SIO_I2C, SIO_CLK_DIV1, 8'h07, d);
    i2c_start = 1'b1;
    while (!busy) @(negedge clock);
    i2c_start = 1'b0;
    wr(8'h55);
    while (sda_w !== 1'b0) @(negedge clock);
    chk(scl_w, 1);
    cnt = 0;
    ps = scl_w;
    while (sda_w !== 1'b1) begin
      @(negedge clock);
      cnt = (ps && !scl_w) ? 0 : cnt + 1;
      ps = scl_w;
    end
    chk(cnt, d * 8);
    while (busy) @(negedge clock);
    i2c_stop = 1'b1;
    while (!busy) @(negedge clock);
    i2c_stop = 1'b0;
    while (sda_w !== 1'b0) @(negedge clock);
    while (sda_w !== 1'b1) @(negedge clock);
    chk(scl_w, 1);
    while (busy) @(negedge clock);
    chk({scl_oe_n, sda_oe_n}, 2'b11);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    {rstn, tx_valid, i2c_start, i2c_stop, rx_read, ovr_clr} = '0;
    tx_data = 8'h00;
    cfg = '{mode: SIO_ASYNC, clk_sel: SIO_CLK_DIV1, brg_div: 8'h00, sda_dly: 1'b0};
    cyc(6);
    rstn = 1'b1;
    chk({tx_ready, busy, rx_out, ovr_err, rts_n, txd, sclk_o, scl_oe_n, sda_oe_n}, 17'h1000f);
    t_rx();
    t_ovr();
    t_fill();
    for (int s = 0; s < 4; s++) t_tx(2'(s), 8'h00, 8'h96);
    t_tx(SIO_CLK_DIV1, 8'h07, 8'h69);
    t_sync();
    t_i2c(1'b0);
    t_i2c(1'b1);
    stop_test();
  end
  // Whole run needs well under 8000 clocks
  initial begin
    #(20000 * 8);
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire
